// ==== core/ltp_params.svh ====
`ifndef LTP_PARAMS_SVH
`define LTP_PARAMS_SVH
// Summary of operation
// - Pattern clock: transmit clock, master when selected
// - Select 0, pattern 00: transmit data passes
// - Pattern 01 sends all ones
// - Select 1, pattern 00 sends all zeros
// - QRSS 2^20-1 in T1, PRBS 2^15-1 E1
// - Pattern 10 sends sequence, optionally inverted
// - Sync while at most 6 errors per 64
// - Sync change latched by edge select, masked interrupt
// - Error select 00 counts sequence errors, 16 bit
// - Analog loop: transmit to receive outputs, line kept
// - Digital loop: transmit to receive outputs, line kept
// - Patterns replace transmit data during local loops
// - Remote loop: recovered receive data to line
// - Loop pins: 01 analog, 10 digital, 11 remote
// - Pattern 11 sends code; receive tolerates errors
// - Code starts at 11, stops at 0/00
// - Transmit code 8-bit field, length 5 to 8
// - Activate, deactivate codes each with own length
// - Code detect after 30 ms E1, 40 ms T1
// - Code detect interrupts by edge select, clear on read
// - Auto: activate over 5.1 s sets remote loop
// - Auto: deactivate releases; auto off forces release

// Register indices; byte address is four times the index
`define LTP_IDX_PATTERN 6'h0C
`define LTP_IDX_LOOP 6'h0D
`define LTP_IDX_LENGTH 6'h0E
`define LTP_IDX_TXCODE 6'h0F
`define LTP_IDX_ACTCODE 6'h10
`define LTP_IDX_DEACTCODE 6'h11
`define LTP_IDX_ERRCTRL 6'h12
`define LTP_IDX_INTMASK 6'h13
`define LTP_IDX_EDGESEL 6'h15
`define LTP_IDX_STATUS0 6'h16
`define LTP_IDX_STATUS1 6'h17
`define LTP_IDX_INTSTAT 6'h18
`define LTP_IDX_ERRCNT_LO 6'h1A
`define LTP_IDX_ERRCNT_HI 6'h1B

// Timing and thresholds
`define LTP_CLK_NS 10
`define LTP_TICK_NS 1000000
`define LTP_DETECT_E1_MS 13'h001E
`define LTP_DETECT_T1_MS 13'h0028
`define LTP_AUTO_MS 13'h13EC
`define LTP_SYNC_MAX_ERR 7'h06
`define LTP_CODE_MAX_MISS 7'h08
`define LTP_WINDOW_INIT 7'h40
`define LTP_SEQ_SEED 20'hFFFFF
`endif

// ==== core/ltp_pkg.sv ====
package ltp_pkg;
	typedef enum logic [1:0] {
		LTP_PAT_NORMAL = 2'b00,
		LTP_PAT_ONES = 2'b01,
		LTP_PAT_SEQ = 2'b10,
		LTP_PAT_CODE = 2'b11
	} ltp_pattern_e;

	typedef struct packed {
		logic [2:0] phase;
		logic [5:0] bitCnt;
		logic [6:0] missCnt;
		logic present;
		logic [12:0] msCnt;
		logic status;
	} ltp_code_det_s;

	// Feedback of the sequence register: x^15+x^14+1 or x^20+x^17+1
	function automatic logic ltp_seq_fb(input logic [19:0] s, input logic e1);
		ltp_seq_fb = e1 ? (s[14] ^ s[13]) : (s[19] ^ s[16]);
	endfunction

	function automatic logic ltp_edge_hit(input logic old, input logic now, input logic anyEdge);
		ltp_edge_hit = anyEdge ? (old != now) : (!old && now);
	endfunction

	// Advance a code phase modulo the code length (5 + lenSel)
	function automatic logic [2:0] ltp_wrap(input logic [2:0] p, input logic [2:0] step,
		input logic [1:0] lenSel);
		logic [3:0] sum;
		logic [3:0] len;
		sum = {1'b0, p} + {1'b0, step};
		len = 4'h5 + {2'h0, lenSel};
		ltp_wrap = (sum >= len) ? 3'(sum - len) : sum[2:0];
	endfunction
endpackage

// ==== core/ltp_seq_gen.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "ltp_params.svh"
module ltp_seq_gen (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic stepEn,
	input wire logic e1Mode,
	output logic seqBit
);
	import ltp_pkg::*;

	typedef struct packed {
		logic [19:0] lfsr;
		logic outBit;
	} ltp_gen_s;

	ltp_gen_s r;
	ltp_gen_s n;
	logic fb;

	always_comb begin
		n = r;
		fb = ltp_seq_fb(r.lfsr, e1Mode);
		if (stepEn) begin
			n.lfsr = {r.lfsr[18:0], fb};
			n.outBit = fb | (!e1Mode && r.lfsr[13:0] == 14'h0000);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			r <= '{lfsr: `LTP_SEQ_SEED, outBit: 1'b1};
		end else begin
			r <= n;
		end
	end

	assign seqBit = r.outBit;
endmodule
`default_nettype wire

// ==== core/ltp_top.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "ltp_params.svh"
module ltp_top #(
	parameter int TICK_CYCLES = `LTP_TICK_NS / `LTP_CLK_NS
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic hwMode,
	input wire logic [1:0] pattern_select_pins,
	input wire logic [1:0] loop_select_pins,
	input wire logic e1Mode,
	input wire logic txClkEn,
	input wire logic mclkEn,
	input wire logic txData,
	input wire logic rxClkEn,
	input wire logic rxData,
	output logic lineTxData,
	output logic lineTxStrobe,
	output logic rxOutData,
	output logic rxOutStrobe,
	output logic analogLoopActive,
	output logic digitalLoopActive,
	output logic remoteLoopActive,
	output logic irq
);
	import ltp_pkg::*;

	typedef struct packed {
		logic waitReq;
		logic [7:0] readData;
		logic [1:0] pattern_select;
		logic pattern_clock_select;
		logic sequence_invert;
		logic analog_loop_enable;
		logic digital_loop_enable;
		logic remote_loop_enable;
		logic auto_remote_loop_enable;
		logic [5:0] codeLengths;
		logic [7:0] tx_loop_code;
		logic [7:0] rx_activate_code;
		logic [7:0] rx_deactivate_code;
		logic [1:0] errorTypeSelect;
		logic [2:0] intMask;
		logic [2:0] edgeSelect;
		logic [2:0] intStat;
		logic [2:0] txCodePhase;
		logic [19:0] chkHist;
		logic [63:0] errWin;
		logic [6:0] errCnt;
		logic sequence_sync_status;
		logic [15:0] errCount;
		ltp_code_det_s [1:0] det;
		logic remote_loop_status;
		logic [16:0] tickCnt;
		logic lineTxData;
		logic lineTxStrobe;
		logic rxOutData;
		logic rxOutStrobe;
		logic analogLoopActive;
		logic digitalLoopActive;
		logic remoteLoopActive;
		logic irq;
	} ltp_top_s;

	localparam ltp_top_s RST_VAL = '{waitReq: 1'b1, errWin: '1, errCnt: `LTP_WINDOW_INIT,
		default: '0};

	ltp_top_s r;
	ltp_top_s n;
	logic seqBit;
	logic [1:0] patEff;
	logic clkSelEff;
	logic invEff;
	logic analogEff;
	logic digitalEff;
	logic remoteEff;
	logic refEn;
	logic insert;
	logic sigStrobe;
	logic sigBit;
	logic seqStep;
	logic rxStrobe;
	logic rxBit;
	logic chkBit;
	logic chkErr;
	logic [6:0] cntNext;
	logic tick;
	logic [12:0] detLimit;
	logic [7:0] code;
	logic [1:0] lenSel;
	logic miss;
	logic [6:0] missNext;
	logic [2:0] hits;
	logic [2:0] clrMask;
	logic req;
	logic done;
	logic [5:0] idx;
	logic [7:0] rdMux;
	logic [7:0] wd;

	ltp_seq_gen u_seq_gen (
		.clk_sys(clk_sys),
		.rst(rst),
		.stepEn(seqStep),
		.e1Mode(e1Mode),
		.seqBit(seqBit)
	);

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		n = r;
		code = 8'h00;
		lenSel = 2'b00;
		miss = 1'b0;
		missNext = 7'h00;
		rdMux = 8'h00;
		patEff = hwMode ? pattern_select_pins : r.pattern_select;
		clkSelEff = hwMode ? 1'b0 : r.pattern_clock_select;
		invEff = hwMode ? 1'b0 : r.sequence_invert;
		analogEff = hwMode ? (loop_select_pins == 2'b01) : r.analog_loop_enable;
		digitalEff = hwMode ? (loop_select_pins == 2'b10) : r.digital_loop_enable;
		remoteEff = (hwMode ? (loop_select_pins == 2'b11) : r.remote_loop_enable)
			| r.remote_loop_status;
		refEn = clkSelEff ? mclkEn : txClkEn;
		insert = clkSelEff || (patEff != LTP_PAT_NORMAL);
		sigStrobe = insert ? refEn : txClkEn;
		case (patEff)
			LTP_PAT_NORMAL: sigBit = insert ? 1'b0 : txData;
			LTP_PAT_ONES: sigBit = 1'b1;
			LTP_PAT_SEQ: sigBit = seqBit ^ invEff;
			default: sigBit = r.tx_loop_code[3'(3'h4 + {1'b0, r.codeLengths[1:0]}) - r.txCodePhase];
		endcase
		seqStep = sigStrobe && (patEff == LTP_PAT_SEQ);
		// Code restarts from its first bit
		if (patEff != LTP_PAT_CODE) begin
			n.txCodePhase = 3'h0;
		end else if (sigStrobe) begin
			n.txCodePhase = ltp_wrap(r.txCodePhase, 3'h1, r.codeLengths[1:0]);
		end

		n.lineTxStrobe = remoteEff ? rxClkEn : sigStrobe;
		if (n.lineTxStrobe) begin
			n.lineTxData = remoteEff ? rxData : sigBit;
		end
		rxStrobe = (analogEff || digitalEff) ? sigStrobe : rxClkEn;
		rxBit = (analogEff || digitalEff) ? sigBit : rxData;
		n.rxOutStrobe = rxStrobe;
		if (rxStrobe) begin
			n.rxOutData = rxBit;
		end
		n.analogLoopActive = analogEff;
		n.digitalLoopActive = digitalEff;
		n.remoteLoopActive = remoteEff;

		////////////////////////////////////////////////////////////////////////////
		// Self-synchronising checker
		chkBit = rxBit ^ invEff;
		chkErr = chkBit ^ ltp_seq_fb(r.chkHist, e1Mode);
		cntNext = 7'(r.errCnt + {6'h00, chkErr} - {6'h00, r.errWin[63]});
		if (rxStrobe) begin
			n.chkHist = {r.chkHist[18:0], chkBit};
			n.errWin = {r.errWin[62:0], chkErr};
			n.errCnt = cntNext;
			n.sequence_sync_status = (cntNext <= `LTP_SYNC_MAX_ERR);
			if (chkErr && r.errorTypeSelect == 2'b00 && r.errCount != 16'hFFFF) begin
				n.errCount = r.errCount + 16'h0001;
			end
		end

		// Millisecond divider for the persistence timers
		tick = (r.tickCnt == 17'(TICK_CYCLES - 1));
		n.tickCnt = tick ? 17'h00000 : r.tickCnt + 17'h00001;
		detLimit = e1Mode ? `LTP_DETECT_E1_MS : `LTP_DETECT_T1_MS;
		for (int i = 0; i < 2; i++) begin
			code = (i == 1) ? r.rx_deactivate_code : r.rx_activate_code;
			lenSel = r.codeLengths[2 + 2 * i +: 2];
			miss = rxBit != code[3'(3'h4 + {1'b0, lenSel}) - r.det[i].phase];
			missNext = r.det[i].missCnt + {6'h00, miss};
			if (rxStrobe) begin
				n.det[i].bitCnt = r.det[i].bitCnt + 6'h01;
				// Block vote tolerates bit errors; failing blocks slip phase
				if (r.det[i].bitCnt == 6'h3F) begin
					n.det[i].present = (missNext <= `LTP_CODE_MAX_MISS);
					n.det[i].phase = ltp_wrap(r.det[i].phase, n.det[i].present ? 3'h1 : 3'h2,
						lenSel);
					n.det[i].missCnt = 7'h00;
				end else begin
					n.det[i].missCnt = missNext;
					n.det[i].phase = ltp_wrap(r.det[i].phase, 3'h1, lenSel);
				end
			end
			if (!n.det[i].present) begin
				n.det[i].msCnt = 13'h0000;
			end else if (tick && r.det[i].msCnt != 13'h1FFF) begin
				n.det[i].msCnt = r.det[i].msCnt + 13'h0001;
			end
			n.det[i].status = n.det[i].present && (n.det[i].msCnt > detLimit);
		end

		if (!r.auto_remote_loop_enable) begin
			n.remote_loop_status = 1'b0;
		end else if (r.det[1].msCnt > `LTP_AUTO_MS) begin
			n.remote_loop_status = 1'b0;
		end else if (r.det[0].msCnt > `LTP_AUTO_MS) begin
			n.remote_loop_status = 1'b1;
		end

		////////////////////////////////////////////////////////////////////////////
		req = avs_read || avs_write;
		done = req && !r.waitReq;
		idx = avs_address[7:2];
		wd = avs_writedata[7:0];
		n.waitReq = !(req && r.waitReq);
		hits[0] = ltp_edge_hit(r.sequence_sync_status, n.sequence_sync_status, r.edgeSelect[0]);
		hits[1] = ltp_edge_hit(r.det[0].status, n.det[0].status, r.edgeSelect[1]);
		hits[2] = ltp_edge_hit(r.det[1].status, n.det[1].status, r.edgeSelect[2]);
		// Only bits already reported are cleared, so late events survive the read
		clrMask = (done && avs_read && idx == `LTP_IDX_INTSTAT) ? r.readData[2:0] : 3'h0;
		n.intStat = (r.intStat & ~clrMask) | hits;
		n.irq = |(r.intStat & r.intMask);

		if (idx == `LTP_IDX_PATTERN) begin
			rdMux = {4'h0, r.sequence_invert, r.pattern_clock_select, r.pattern_select};
		end else if (idx == `LTP_IDX_LOOP) begin
			rdMux = {4'h0, r.auto_remote_loop_enable, r.remote_loop_enable,
				r.digital_loop_enable, r.analog_loop_enable};
		end else if (idx == `LTP_IDX_LENGTH) begin
			rdMux = {2'h0, r.codeLengths};
		end else if (idx == `LTP_IDX_TXCODE) begin
			rdMux = r.tx_loop_code;
		end else if (idx == `LTP_IDX_ACTCODE) begin
			rdMux = r.rx_activate_code;
		end else if (idx == `LTP_IDX_DEACTCODE) begin
			rdMux = r.rx_deactivate_code;
		end else if (idx == `LTP_IDX_ERRCTRL) begin
			rdMux = {6'h00, r.errorTypeSelect};
		end else if (idx == `LTP_IDX_INTMASK) begin
			rdMux = {5'h00, r.intMask};
		end else if (idx == `LTP_IDX_EDGESEL) begin
			rdMux = {5'h00, r.edgeSelect};
		end else if (idx == `LTP_IDX_STATUS0) begin
			rdMux = {5'h00, r.det[1].status, r.det[0].status, r.sequence_sync_status};
		end else if (idx == `LTP_IDX_STATUS1) begin
			rdMux = {7'h00, r.remote_loop_status};
		end else if (idx == `LTP_IDX_INTSTAT) begin
			rdMux = {5'h00, r.intStat};
		end else if (idx == `LTP_IDX_ERRCNT_LO) begin
			rdMux = r.errCount[7:0];
		end else if (idx == `LTP_IDX_ERRCNT_HI) begin
			rdMux = r.errCount[15:8];
		end
		if (avs_read && r.waitReq) begin
			n.readData = rdMux;
		end

		if (done && avs_write && avs_byteenable[0]) begin
			if (idx == `LTP_IDX_PATTERN) begin
				n.pattern_select = wd[1:0];
				n.pattern_clock_select = wd[2];
				n.sequence_invert = wd[3];
			end else if (idx == `LTP_IDX_LOOP) begin
				n.analog_loop_enable = wd[0];
				n.digital_loop_enable = wd[1];
				n.remote_loop_enable = wd[2];
				n.auto_remote_loop_enable = wd[3];
			end else if (idx == `LTP_IDX_LENGTH) begin
				n.codeLengths = wd[5:0];
			end else if (idx == `LTP_IDX_TXCODE) begin
				n.tx_loop_code = wd;
			end else if (idx == `LTP_IDX_ACTCODE) begin
				n.rx_activate_code = wd;
			end else if (idx == `LTP_IDX_DEACTCODE) begin
				n.rx_deactivate_code = wd;
			end else if (idx == `LTP_IDX_ERRCTRL) begin
				n.errorTypeSelect = wd[1:0];
			end else if (idx == `LTP_IDX_INTMASK) begin
				n.intMask = wd[2:0];
			end else if (idx == `LTP_IDX_EDGESEL) begin
				n.edgeSelect = wd[2:0];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			r <= RST_VAL;
		end else begin
			r <= n;
		end
	end

	assign avs_readdata = {24'h000000, r.readData};
	assign avs_waitrequest = r.waitReq;
	assign lineTxData = r.lineTxData;
	assign lineTxStrobe = r.lineTxStrobe;
	assign rxOutData = r.rxOutData;
	assign rxOutStrobe = r.rxOutStrobe;
	assign analogLoopActive = r.analogLoopActive;
	assign digitalLoopActive = r.digitalLoopActive;
	assign remoteLoopActive = r.remoteLoopActive;
	assign irq = r.irq;

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	a_mclk_reference: assert property (clkSelEff && mclkEn && !remoteEff |=> lineTxStrobe)
		else $error("master clock strobe not sent");
	a_normal_pass: assert property (!insert && txClkEn && !remoteEff
		|=> lineTxStrobe && lineTxData == $past(txData))
		else $error("normal data not passed");
	a_all_ones: assert property (patEff == LTP_PAT_ONES && refEn && !remoteEff
		|=> lineTxData)
		else $error("all ones not sent");
	a_all_zeros: assert property (clkSelEff && patEff == LTP_PAT_NORMAL && mclkEn
		&& !remoteEff |=> !lineTxData)
		else $error("all zeros not sent");
	a_sync_window: assert property (rxStrobe && cntNext > `LTP_SYNC_MAX_ERR
		|=> !r.sequence_sync_status)
		else $error("sync kept with too many errors");
	a_sync_latch: assert property ($rose(r.sequence_sync_status) |-> r.intStat[0])
		else $error("sync rise not latched");
	a_irq_mask: assert property (r.intStat[0] && r.intMask[0] |=> irq)
		else $error("masked interrupt missing");
	a_local_loop: assert property ((analogEff || digitalEff) && sigStrobe
		|=> rxOutStrobe && rxOutData == lineTxData)
		else $error("local loop not routed");
	a_remote_route: assert property (remoteEff && rxClkEn
		|=> lineTxStrobe && lineTxData == $past(rxData))
		else $error("remote loop not routed");
	a_auto_release: assert property (!r.auto_remote_loop_enable |=> !r.remote_loop_status)
		else $error("remote loop not released");
	a_bus_answer: assert property (req && r.waitReq |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer not one wait state");

	c_sync_rise: cover property ($rose(r.sequence_sync_status));
	c_activate: cover property ($rose(r.det[0].status));
	c_auto_loop: cover property ($rose(r.remote_loop_status));
	c_int_read: cover property (clrMask != 3'h0);
endmodule
`default_nettype wire

// ==== tb/ltp_line_partner.sv ====
`timescale 1ns/100ps
`default_nettype none
module ltp_line_partner (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [1:0] mode,
	input wire logic [7:0] code,
	input wire logic [1:0] lenSel,
	input wire logic lineTxData,
	input wire logic lineTxStrobe,
	output logic rxClkEn,
	output logic rxData
);
	integer seed = 32'h3E44;
	logic [2:0] ph;
	// Modes: 0 silent, 1 echo of our line, 2 random bits, 3 repeated code
	always @(posedge clk_sys) begin
		if (rst) begin
			rxClkEn <= 1'b0;
			rxData <= 1'b0;
			ph <= 3'h0;
		end else begin
			rxClkEn <= (mode == 2'h1) ? lineTxStrobe : (mode != 2'h0);
			if (mode == 2'h1 && lineTxStrobe) begin
				rxData <= lineTxData;
			end else if (mode == 2'h2) begin
				rxData <= 1'($random(seed));
			end else if (mode == 2'h3) begin
				rxData <= code[ph];
				ph <= (ph == 3'h0) ? ({1'b0, lenSel} + 3'h4) : (ph - 3'h1);
			end else begin
				// No valid bit: show the inverse of the last one, never a held value
				rxData <= ~rxData;
			end
		end
	end
endmodule
`default_nettype wire

// ==== tb/line_test_pattern_loopback_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "ltp_params.svh"
module line_test_pattern_loopback_bench;
	import ltp_pkg::*;
	localparam logic [5:0] pat = `LTP_IDX_PATTERN, lp = `LTP_IDX_LOOP, len = `LTP_IDX_LENGTH;
	localparam logic [5:0] txc = `LTP_IDX_TXCODE, msk = `LTP_IDX_INTMASK;
	localparam logic [5:0] st0 = `LTP_IDX_STATUS0, st1 = `LTP_IDX_STATUS1, ist = `LTP_IDX_INTSTAT;
	localparam logic [5:0] regs [12] = '{pat, lp, len, txc, `LTP_IDX_ACTCODE, `LTP_IDX_DEACTCODE,
		`LTP_IDX_ERRCTRL, msk, `LTP_IDX_EDGESEL, st0, st1, ist};
	logic clk_sys, rst, avs_read, avs_write, avs_waitrequest, hwMode, e1Mode, txClkEn, mclkEn;
	logic txData, rxClkEn, rxData, lineTxData, lineTxStrobe, rxOutData, rxOutStrobe, irq;
	logic analogLoopActive, digitalLoopActive, remoteLoopActive;
	logic [7:0] avs_address, lo, hi, code;
	logic [31:0] avs_writedata, avs_readdata;
	logic [3:0] avs_byteenable;
	logic [1:0] pattern_select_pins, loop_select_pins, pMode, pLen, r;
	logic [15:0] bits;
	logic b;
	// Bits that each writable register keeps
	localparam logic [7:0] masks [9] = '{8'h0F, 8'h0F, 8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'h03, 8'h07,
		8'h07};
	integer seed = 32'h3E44;
	int err_count = 0, checked = 0, cycles = 0;

	ltp_top #(.TICK_CYCLES(5)) ltp_top_inst (.clk_sys(clk_sys), .rst(rst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .hwMode(hwMode),
		.pattern_select_pins(pattern_select_pins), .loop_select_pins(loop_select_pins),
		.e1Mode(e1Mode), .txClkEn(txClkEn), .mclkEn(mclkEn), .txData(txData),
		.rxClkEn(rxClkEn), .rxData(rxData), .lineTxData(lineTxData),
		.lineTxStrobe(lineTxStrobe), .rxOutData(rxOutData), .rxOutStrobe(rxOutStrobe),
		.analogLoopActive(analogLoopActive), .digitalLoopActive(digitalLoopActive),
		.remoteLoopActive(remoteLoopActive), .irq(irq));
	ltp_line_partner ltp_line_partner_inst (.clk_sys(clk_sys), .rst(rst), .mode(pMode),
		.code(code), .lenSel(pLen), .lineTxData(lineTxData), .lineTxStrobe(lineTxStrobe),
		.rxClkEn(rxClkEn), .rxData(rxData));

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("mismatches %0d, comparisons %0d", err_count, checked);
		if (err_count == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Request held until waitrequest is seen low, released only after that edge
	task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge clk_sys);
		avs_address <= {idx, 2'b00};
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= {24'h0, d};
		// A slave that never answers is caught by the cycle limit
		do begin
			@(posedge clk_sys);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata[7:0];
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	task automatic wreg(input logic [5:0] i, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, i, d, q);
	endtask

	task automatic rchk(input logic [5:0] i, input logic [7:0] e);
		logic [7:0] q;
		bus(1'b0, i, 8'h00, q);
		chk(q, e);
	endtask

	// One bit from the chosen source clock; returns {strobe, data} a cycle later
	task automatic txbit(input logic useM, input logic d, output logic [1:0] q);
		@(posedge clk_sys);
		txData <= d;
		txClkEn <= !useM;
		mclkEn <= useM;
		@(posedge clk_sys);
		txClkEn <= 1'b0;
		mclkEn <= 1'b0;
		@(negedge clk_sys);
		q = {lineTxStrobe, lineTxData};
	endtask

	function automatic logic rotok(input logic [7:0] c, input logic [1:0] ls, input logic [15:0] b);
		int l;
		logic m;
		rotok = 1'b0;
		l = 5 + ls;
		for (int s = 0; s < l; s++) begin
			m = 1'b1;
			for (int i = 0; i < 16; i++)
				if (b[15 - i] !== c[l - 1 - ((s + i) % l)])
					m = 1'b0;
			if (m)
				rotok = 1'b1;
		end
	endfunction

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 40000) begin
			err_count++;
			end_of_test();
		end
	end

	////////////////////////////////////////////////////////////////
	initial begin
		rst = 1'b1;
		{avs_read, avs_write, hwMode, e1Mode, txClkEn, mclkEn, txData} = '0;
		avs_address = '0;
		avs_writedata = '0;
		avs_byteenable = 4'hF;
		{pattern_select_pins, loop_select_pins, pMode, pLen} = '0;
		code = '0;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		foreach (regs[i]) rchk(regs[i], 8'h00);
		rchk(6'h3F, 8'h00);
		for (int i = 0; i < 9; i++) begin
			code = 8'($random(seed));
			wreg(regs[i], code);
			rchk(regs[i], code & masks[i]);
			wreg(regs[i], 8'h00);
		end
		wreg(st0, 8'hFF);
		rchk(st0, 8'h00);
		avs_byteenable <= 4'h0;
		wreg(txc, 8'h5A);
		avs_byteenable <= 4'hF;
		rchk(txc, 8'h00);
		repeat (8) begin
			b = 1'($random(seed));
			txbit(1'b0, b, r);
			chk(r, {1'b1, b});
		end
		wreg(pat, 8'h05);
		txbit(1'b0, 1'b0, r);
		chk(r[1], 1'b0);
		txbit(1'b1, 1'b0, r);
		chk(r, 2'b11);
		wreg(pat, 8'h04);
		txbit(1'b1, 1'b1, r);
		chk(r, 2'b10);
		wreg(pat, 8'h01);
		wreg(lp, 8'h01);
		repeat (4) txbit(1'b0, 1'b0, r);
		chk(r, 2'b11);
		chk({rxOutStrobe, rxOutData, analogLoopActive}, 3'b111);
		wreg(pat, 8'h04);
		wreg(lp, 8'h02);
		repeat (4) txbit(1'b1, 1'b1, r);
		chk({rxOutStrobe, rxOutData, digitalLoopActive}, 3'b101);
		wreg(lp, 8'h00);
		wreg(pat, 8'h00);
		hwMode <= 1'b1;
		for (int k = 1; k < 4; k++) begin
			@(posedge clk_sys);
			loop_select_pins <= 2'(k);
			repeat (3) @(negedge clk_sys);
			chk({remoteLoopActive, digitalLoopActive, analogLoopActive}, 1 << (k - 1));
		end
		@(posedge clk_sys);
		loop_select_pins <= 2'b00;
		pattern_select_pins <= 2'b01;
		repeat (2) txbit(1'b0, 1'b0, r);
		chk(r, 2'b11);
		@(posedge clk_sys);
		hwMode <= 1'b0;
		pattern_select_pins <= 2'b00;
		for (int t = 0; t < 4; t++) begin
			code = 8'($random(seed));
			wreg(len, 8'(t));
			wreg(txc, code);
			wreg(pat, 8'h03);
			txbit(1'b0, 1'b0, r);
			for (int i = 0; i < 16; i++) begin
				txbit(1'b0, 1'b0, r);
				bits = {bits[14:0], r[0]};
			end
			chk(rotok(code, 2'(t), bits), 1'b1);
			wreg(pat, 8'h00);
			txbit(1'b0, code[0], r);
			chk(r, {1'b1, code[0]});
		end
		e1Mode <= 1'b1;
		pMode <= 2'h1;
		wreg(msk, 8'h01);
		wreg(pat, 8'h02);
		@(posedge clk_sys);
		txClkEn <= 1'b1;
		repeat (500) @(posedge clk_sys);
		txClkEn <= 1'b0;
		rchk(st0, 8'h01);
		@(negedge clk_sys);
		chk(irq, 1'b1);
		rchk(ist, 8'h01);
		repeat (2) @(negedge clk_sys);
		chk(irq, 1'b0);
		@(posedge clk_sys);
		pMode <= 2'h2;
		repeat (400) @(posedge clk_sys);
		rchk(st0, 8'h00);
		rchk(ist, 8'h00);
		bus(1'b0, `LTP_IDX_ERRCNT_LO, 8'h00, lo);
		bus(1'b0, `LTP_IDX_ERRCNT_HI, 8'h00, hi);
		chk({hi, lo} != 16'h0000, 1'b1);
		// Inverted QRSS in T1 mode, sync changes captured on any edge
		e1Mode <= 1'b0;
		pMode <= 2'h1;
		wreg(`LTP_IDX_EDGESEL, 8'h01);
		wreg(pat, 8'h0A);
		txClkEn <= 1'b1;
		repeat (600) @(posedge clk_sys);
		txClkEn <= 1'b0;
		rchk(st0, 8'h01);
		rchk(ist, 8'h01);
		pMode <= 2'h2;
		repeat (400) @(posedge clk_sys);
		rchk(st0, 8'h00);
		rchk(ist, 8'h01);
		wreg(`LTP_IDX_EDGESEL, 8'h00);
		wreg(pat, 8'h00);
		wreg(len, 8'h30);
		wreg(`LTP_IDX_ACTCODE, 8'h01);
		wreg(`LTP_IDX_DEACTCODE, 8'h07);
		wreg(msk, 8'h06);
		wreg(lp, 8'h08);
		code <= 8'h01;
		pLen <= 2'b00;
		pMode <= 2'h3;
		repeat (100) @(posedge clk_sys);
		rchk(st0, 8'h00);
		// Room for phase slips through every rotation, then the persistence time
		repeat (500) @(posedge clk_sys);
		rchk(st0, 8'h02);
		@(negedge clk_sys);
		chk(irq, 1'b1);
		rchk(ist, 8'h02);
		rchk(ist, 8'h00);
		repeat (26000) @(posedge clk_sys);
		rchk(st1, 8'h01);
		chk(remoteLoopActive, 1'b1);
		pMode <= 2'h2;
		repeat (500) @(posedge clk_sys);
		rchk(st1, 8'h01);
		code <= 8'h07;
		pLen <= 2'b11;
		pMode <= 2'h3;
		repeat (900) @(posedge clk_sys);
		rchk(st0, 8'h04);
		rchk(st1, 8'h01);
		wreg(lp, 8'h00);
		// Enable clears status one cycle later, the loop output one more
		repeat (3) @(negedge clk_sys);
		chk(remoteLoopActive, 1'b0);
		rchk(st1, 8'h00);
		end_of_test();
	end
endmodule
`default_nettype wire
